// ===== verilog/lcsd_pkg.sv
// Shared constants and types for the LCD common scan driver block.
// Assumes one 40 MHz bus clock and AHB-Lite access to the registers.
package lcsd_pkg;

  // Clock rate of hclk in kHz.
  localparam int unsigned CLK_KHZ = 40000;

  // Chain geometry: two chains of fifty stages each.
  localparam int unsigned STAGES     = 100;
  localparam int unsigned CHAIN_LEN  = 50;
  localparam int unsigned LO_FIRST   = 0;
  localparam int unsigned LO_LAST    = 49;
  localparam int unsigned UP_FIRST   = 50;
  localparam int unsigned UP_LAST    = 99;
  localparam int unsigned BYPASS_LEN = 10;

  // Two-bit level codes that steer the analogue switches.
  localparam logic [1:0] LVL_ONE  = 2'h0;
  localparam logic [1:0] LVL_TWO  = 2'h1;
  localparam logic [1:0] LVL_FIVE = 2'h2;
  localparam logic [1:0] LVL_LOWEST = 2'h3;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_ROWS0    = 8'h08;
  localparam logic [7:0] OFS_ROWS1    = 8'h0c;
  localparam logic [7:0] OFS_ROWS2    = 8'h10;
  localparam logic [7:0] OFS_ROWS3    = 8'h14;

  // Field positions.
  localparam int unsigned CTRL_HOLD_BIT = 0;
  localparam logic        CTRL_RESET    = 1'b0;

  // AHB encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Static mode pins carried together.
  typedef struct packed {
    logic shift_direction_select;
    logic upper_bypass_select;
    logic lower_bypass_select;
  } lcsd_mode_t;

endpackage : lcsd_pkg

// ===== verilog/lcsd_fall_detect.sv
// Falling-edge detector for the scan clock, sampled on hclk.
// Assumes the scan clock is synchronous to hclk and far slower than it.
`timescale 1ns/100ps
`default_nettype none
module lcsd_fall_detect
  import lcsd_pkg::*;
(
  // Clock and reset.
  input  wire logic hclk,
  input  wire logic hresetn,
  // Sampled level and enable pulse.
  input  wire logic level_in,
  output logic      fall_pulse
);

  // Previous sample of the scan clock level.
  logic prev_level;

  // Capture the level each cycle; reset assumes the line idles high.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_level <= 1'b1;
    end
    else
    begin
      prev_level <= level_in;
    end
  end

  // A high-to-low step gives a one-cycle enable.
  assign fall_pulse = prev_level & ~level_in;

endmodule : lcsd_fall_detect
`default_nettype wire

// ===== verilog/lcsd_top.sv
// Top of the LCD common scan driver: two shift chains, level encode, regs.
// Assumes pins are synchronous to hclk and an AHB-Lite master with one slave.
//
// Notes on behaviour
// - Two fifty-stage chains, direction pin shared.
// - Chains advance only on scan clock falling.
// - Forward: port one/fifty-one in, fifty/hundred out.
// - Reverse: port fifty/hundred in, one/fifty-one out.
// - Forward lower bypass skips outputs one to ten.
// - Reverse upper bypass skips outputs ninety-one upward.
// - Each output follows its own stage.
// - Polarity and bit pick one of four levels.
// - Blanking low forces level one everywhere.
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module lcsd_top
  import lcsd_pkg::*;
(
  // Clock and reset.
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // AHB-Lite slave.
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // Scan control pins.
  input  wire logic                scan_clock,
  input  wire lcsd_mode_t          mode,
  input  wire logic                frame_polarity,
  input  wire logic                blank_force_n,
  // Two-way chain ports.
  input  wire logic                chain_port_one_i,
  output logic                     chain_port_one_o,
  output logic                     chain_port_one_oe,
  input  wire logic                chain_port_fifty_i,
  output logic                     chain_port_fifty_o,
  output logic                     chain_port_fifty_oe,
  input  wire logic                chain_port_fifty_one_i,
  output logic                     chain_port_fifty_one_o,
  output logic                     chain_port_fifty_one_oe,
  input  wire logic                chain_port_hundred_i,
  output logic                     chain_port_hundred_o,
  output logic                     chain_port_hundred_oe,
  // Row level codes.
  output logic [STAGES-1:0][1:0]   row_level_outputs
);

  logic              fall_pulse;    // One cycle per scan clock fall.
  logic              hold;          // Software freeze of shifting.
  logic              shift_en;      // Qualified shift enable.
  logic [STAGES-1:0] stage;         // Both chains, lower then upper.
  logic [STAGES-1:0] next_stage;    // Next value of each stage.
  logic              dir;           // High means reverse shifting.
  logic              lo_byp;        // Forward bypass of first ten.
  logic              up_byp;        // Reverse bypass of last ten.

  assign dir    = mode.shift_direction_select;
  assign lo_byp = mode.lower_bypass_select & ~dir;
  assign up_byp = mode.upper_bypass_select & dir;

  // Edge detector on the sampled scan clock.
  lcsd_fall_detect u_fall (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .level_in   (scan_clock),
    .fall_pulse (fall_pulse)
  );

  assign shift_en = fall_pulse & ~hold;

  // Per-stage next value; the chains never pass data to each other.
  for (genvar i = 0; i < STAGES; i++)
  begin : g_stage
    logic fwd_val;  // Value when shifting up.
    logic rev_val;  // Value when shifting down.
    if (i == LO_FIRST)
    begin : g_lo_head
      assign fwd_val = lo_byp ? stage[i] : chain_port_one_i;
      assign rev_val = stage[i+1];
    end
    else if (i == LO_FIRST + BYPASS_LEN)
    begin : g_lo_skip
      assign fwd_val = lo_byp ? chain_port_one_i : stage[i-1];
      assign rev_val = stage[i+1];
    end
    else if (i < LO_FIRST + BYPASS_LEN)
    begin : g_lo_byp
      // Bypassed stages keep their bits while skipped.
      assign fwd_val = lo_byp ? stage[i] : stage[i-1];
      assign rev_val = stage[i+1];
    end
    else if (i == LO_LAST)
    begin : g_lo_tail
      assign fwd_val = stage[i-1];
      assign rev_val = chain_port_fifty_i;
    end
    else if (i == UP_FIRST)
    begin : g_up_head
      assign fwd_val = chain_port_fifty_one_i;
      assign rev_val = stage[i+1];
    end
    else if (i == UP_LAST - BYPASS_LEN)
    begin : g_up_skip
      assign fwd_val = stage[i-1];
      assign rev_val = up_byp ? chain_port_hundred_i : stage[i+1];
    end
    else if (i > UP_LAST - BYPASS_LEN && i < UP_LAST)
    begin : g_up_byp
      assign fwd_val = stage[i-1];
      assign rev_val = up_byp ? stage[i] : stage[i+1];
    end
    else if (i == UP_LAST)
    begin : g_up_tail
      assign fwd_val = stage[i-1];
      assign rev_val = up_byp ? stage[i] : chain_port_hundred_i;
    end
    else
    begin : g_mid
      assign fwd_val = stage[i-1];
      assign rev_val = stage[i+1];
    end
    assign next_stage[i] = dir ? rev_val : fwd_val;
  end

  // Chain flops; reset clears them so the panel starts unselected.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage <= '0;
    end
    else if (shift_en)
    begin
      stage <= next_stage;
    end
  end

  assign chain_port_fifty_o      = stage[LO_LAST];
  assign chain_port_hundred_o    = stage[UP_LAST];
  assign chain_port_one_o        = stage[LO_FIRST];
  assign chain_port_fifty_one_o  = stage[UP_FIRST];
  assign chain_port_fifty_oe     = ~dir;
  assign chain_port_hundred_oe   = ~dir;
  assign chain_port_one_oe       = dir;
  assign chain_port_fifty_one_oe = dir;

  // Level code per output, registered so outputs are glitch free.
  logic [STAGES-1:0][1:0] next_level;  // Decoded level per output.
  for (genvar j = 0; j < STAGES; j++)
  begin : g_level
    assign next_level[j] = !blank_force_n ? LVL_ONE :
                           frame_polarity ?
                             (stage[j] ? LVL_ONE : LVL_FIVE) :
                             (stage[j] ? LVL_LOWEST : LVL_TWO);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      row_level_outputs <= {STAGES{LVL_ONE}};
    end
    else
    begin
      row_level_outputs <= next_level;
    end
  end

  // Bus slave: zero wait states, read data registered in address phase.
  logic        wr_pend;   // Write data phase pending.
  logic [7:0]  wr_addr;   // Latched write offset.
  wire         acc_ok  = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire  [7:0]  ofs     = haddr[7:0];
  wire  [127:0] rows_pad = {28'h0000000, stage};
  logic [31:0] rd_mux;    // Read value for the current address.

  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // Read decode; unmapped offsets read as zero.
  assign rd_mux = (ofs == OFS_CTRL)   ? {31'h0, hold} :
                  (ofs == OFS_STATUS) ? {27'h0, frame_polarity,
                                         blank_force_n, mode} :
                  (ofs == OFS_ROWS0)  ? rows_pad[31:0]   :
                  (ofs == OFS_ROWS1)  ? rows_pad[63:32]  :
                  (ofs == OFS_ROWS2)  ? rows_pad[95:64]  :
                  (ofs == OFS_ROWS3)  ? rows_pad[127:96] : 32'h0;

  // Address phase capture and write commit in the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hold    <= CTRL_RESET;
      hrdata  <= 32'h0;
    end
    else
    begin
      wr_pend <= acc_ok & hwrite;
      wr_addr <= ofs;
      if (acc_ok && !hwrite)
      begin
        hrdata <= rd_mux;
      end
      if (wr_pend && wr_addr == OFS_CTRL)
      begin
        hold <= hwdata[CTRL_HOLD_BIT];
      end
    end
  end

  // Checks on the chain and level logic.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_shift_only_fall: assert property (!shift_en |=> $stable(stage))
    else $error("Chain moved without a scan clock fall.");
  a_fwd_entry: assert property (shift_en && !dir && !lo_byp |=>
      stage[0] == $past(chain_port_one_i) && stage[50] ==
      $past(chain_port_fifty_one_i) && stage[49] == $past(stage[48]))
    else $error("Forward entry wrong.");
  a_rev_entry: assert property (shift_en && dir |=>
      stage[49] == $past(chain_port_fifty_i) && stage[0] == $past(stage[1]))
    else $error("Reverse entry wrong.");
  a_lo_bypass: assert property (shift_en && lo_byp |=>
      stage[10] == $past(chain_port_one_i) && $stable(stage[9:0]))
    else $error("Lower bypass wrong.");
  a_up_bypass: assert property (shift_en && up_byp |=>
      stage[89] == $past(chain_port_hundred_i) && $stable(stage[99:90]))
    else $error("Upper bypass wrong.");
  a_port_dir: assert property (chain_port_one_oe == dir &&
      chain_port_fifty_one_oe == dir && chain_port_fifty_oe == !dir &&
      chain_port_hundred_oe == !dir)
    else $error("Port enables disagree with direction.");
  a_blank_level: assert property (!blank_force_n |=>
      row_level_outputs[0] == LVL_ONE && row_level_outputs[99] == LVL_ONE)
    else $error("Blanking did not force level one.");
  a_level_map: assert property (blank_force_n && !frame_polarity &&
      stage[5] |=> row_level_outputs[5] == LVL_LOWEST)
    else $error("Level map wrong.");
  a_out_stage: assert property (blank_force_n && frame_polarity
      |=> row_level_outputs[60] == ($past(stage[60]) ? LVL_ONE : LVL_FIVE))
    else $error("Output does not follow its stage.");

endmodule : lcsd_top
`default_nettype wire

// ===== testbench/lcsd_ctrl_model.sv
// Timing controller model: makes scan clock falls and entry data.
// Assumes callers enter its task just after a rising hclk edge.
`timescale 1ns/100ps
`default_nettype none
module lcsd_ctrl_model
  import lcsd_pkg::*;
(
  // Bus clock that paces every scan step.
  input  wire logic hclk,
  // Scan drive toward the device.
  output var logic  scan_clock,
  output var logic  scan_data
);
  // The scan clock idles high so that no fall happens between frames.
  initial
  begin
    scan_clock = 1'b1;
    scan_data  = 1'b0;
  end

  // One low cycle, then one high cycle, so each level lasts an hclk.
  // Data flips once sampled so a stale level is never mistaken for a hold.
  // one fall per pulse
  task automatic pulse(input logic d);
    scan_clock <= 1'b0;
    scan_data  <= d;
    @(posedge hclk);
    scan_clock <= 1'b1;
    scan_data  <= ~d;
    @(posedge hclk);
  endtask : pulse
endmodule : lcsd_ctrl_model
`default_nettype wire

// ===== testbench/tb.sv
// Bench for the scan driver: bus access, chain latency and levels.
// Assumes the controller model drives scan clock and entry data.
`timescale 1ns/100ps
`default_nettype none
module tb
  import lcsd_pkg::*;
;
  logic                   hclk = 1'b0;     // Bus clock.
  logic                   hresetn = 1'b0;  // Active-low reset.
  logic                   hsel = 1'b0;     // Bus select.
  logic [31:0]            haddr = 32'h0;   // Bus address.
  logic [1:0]             htrans = 2'h0;   // Transfer kind.
  logic                   hwrite = 1'b0;   // Write strobe.
  logic [31:0]            hwdata = 32'h0;  // Write data.
  logic [2:0]             hsize = 3'h0;    // Transfer size, words only.
  logic [31:0]            sink;            // Read-back of write calls.
  logic                   hready;          // Slave ready fed back.
  logic                   hresp;           // Response, always OKAY.
  logic [31:0]            hrdata;          // Read data.
  logic                   frame_polarity = 1'b0;  // Frame polarity.
  logic                   blank_force_n = 1'b1;   // Blanking, low active.
  lcsd_mode_t             mode = '0;       // Direction and bypass.
  logic                   scan_clock;      // From controller model.
  logic                   scan_data;       // From controller model.
  logic [3:0]             po;              // Port outs: one,50,51,100.
  logic [3:0]             oe;              // Port enables, same order.
  logic [3:0]             pi;              // Port ins, same order.
  logic [STAGES-1:0][1:0] rows;            // Level codes.
  int                     mismatches = 0;  // Failed compares.
  int                     checks = 0;      // All compares.

  // Half period of 12.5 ns gives 40 MHz.
  always #12.5 hclk = ~hclk;

  lcsd_ctrl_model ctl (.hclk(hclk), .scan_clock(scan_clock),
                       .scan_data(scan_data));

  // A port that the device does not drive carries the model's data.
  assign pi = (oe & po) | (~oe & {4{scan_data}});

  lcsd_top uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .scan_clock(scan_clock), .mode(mode),
    .frame_polarity(frame_polarity), .blank_force_n(blank_force_n),
    .chain_port_one_i(pi[0]),
    .chain_port_one_o(po[0]), .chain_port_one_oe(oe[0]),
    .chain_port_fifty_i(pi[1]),
    .chain_port_fifty_o(po[1]), .chain_port_fifty_oe(oe[1]),
    .chain_port_fifty_one_i(pi[2]),
    .chain_port_fifty_one_o(po[2]), .chain_port_fifty_one_oe(oe[2]),
    .chain_port_hundred_i(pi[3]),
    .chain_port_hundred_o(po[3]), .chain_port_hundred_oe(oe[3]),
    .row_level_outputs(rows));

  // Prints the verdict and ends the run.
  task automatic results;
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // Counts a compare and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Waits for hready under a bound, since a hung slave must not stall us.
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1)
    begin
      mismatches++;
      results();
    end
  endtask : wait_rdy

  // One single word transfer: address phase, then data phase.
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : ahb

  // Reads a register and compares it.
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0, rd);
    chk(rd, exp);
    chk(32'(hresp), 32'(HRESP_OKAY));
  endtask : rchk

  // Flushes, sends one marked bit, then watches both exit ports.
  task automatic chain(input lcsd_mode_t m, input int la, input int ua);
    logic d;
    d = m.shift_direction_select;
    // mode only moves while the scan clock idles
    mode <= m;
    @(posedge hclk);
    repeat (50) ctl.pulse(1'b0);
    ctl.pulse(1'b1);
    chk(32'(oe), d ? 32'h5 : 32'ha);
    for (int i = 2; i <= 50; i++)
    begin
      ctl.pulse(1'b0);
      chk(32'({po[d ? 0 : 1], po[d ? 2 : 3]}), 32'({i == la, i == ua}));
    end
  endtask : chain

  // Expected level code for polarity and stage bit.
  function automatic logic [1:0] lvl(input logic f, input logic b);
    return f ? (b ? LVL_ONE : LVL_FIVE) : (b ? LVL_LOWEST : LVL_TWO);
  endfunction : lvl

  // Main sequence: reset, chain modes, hold, registers, levels.
  initial
  begin
    repeat (10) @(posedge hclk);
    chk(32'(rows[0]), 32'(LVL_ONE));
    hresetn <= 1'b1;
    rchk(OFS_CTRL, 32'h0);
    rchk(8'h20, 32'h0);
    chain(3'b100, 50, 50);
    chain(3'b110, 50, 40);
    chain(3'b101, 50, 50);
    chain(3'b001, 40, 50);
    chain(3'b010, 50, 50);
    chain(3'b000, 50, 50);
    ctl.pulse(1'b1);
    repeat (2) ctl.pulse(1'b0);
    rchk(OFS_ROWS0, 32'h4);
    rchk(OFS_ROWS1, 32'h0010_0000);
    rchk(OFS_ROWS3, 32'h0);
    ahb(1'b1, OFS_CTRL, 32'h1, sink);
    rchk(OFS_CTRL, 32'h1);
    repeat (3) ctl.pulse(1'b1);
    rchk(OFS_ROWS0, 32'h4);
    ahb(1'b1, OFS_CTRL, 32'h0, sink);
    rchk(OFS_STATUS, 32'h08);
    // polarity alternates as from frame to frame
    for (int f = 0; f <= 1; f++)
    begin
      frame_polarity <= f[0];
      repeat (3) @(posedge hclk);
      chk(32'(rows[2]), 32'(lvl(f[0], 1'b1)));
      chk(32'(rows[3]), 32'(lvl(f[0], 1'b0)));
    end
    blank_force_n <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(32'(rows[2]), 32'(LVL_ONE));
    chk(32'(rows[3]), 32'(LVL_ONE));
    rchk(OFS_STATUS, 32'h10);
    results();
  end
endmodule : tb
`default_nettype wire
